/* File: common/storm_bank_defines.vh */
// Offsets, field positions, reset values and timing counts of the bank
`ifndef STORM_BANK_DEFINES_VH
`define STORM_BANK_DEFINES_VH

// Register offsets
`define OFS_LIMIT_HIGH_CTRL  8'h06
`define OFS_LIMIT_LOW        8'h07
`define OFS_FACTORY_A        8'h08
`define OFS_FACTORY_B        8'h09
`define OFS_FACTORY_C        8'h0A
`define OFS_LED_TAG          8'h0B

// Reset values
`define RST_LIMIT_HIGH_CTRL  8'h00
`define RST_LIMIT_LOW        8'h63
`define RST_FACTORY_A        8'h00
`define RST_FACTORY_B        8'h24
`define RST_FACTORY_C        8'h35
`define RST_LED_TAG_FIXED    8'h08

// Field positions in the LED/tag register
`define BIT_LED_SEL_HI       7
`define BIT_RSVD_HI          5
`define BIT_TEST_MODE        4
`define BIT_RSVD_LO          2
`define BIT_LED_SEL_LO       1
`define BIT_TAG_MODE         0

// Metering periods in microseconds and clock rate in kHz
`define PERIOD_100M_US       67000
`define PERIOD_10M_US        500000
`define CLK_KHZ              25000
`define PERIOD_100M_CYC      ((`PERIOD_100M_US / 1000) * `CLK_KHZ)
`define PERIOD_10M_CYC       ((`PERIOD_10M_US / 1000) * `CLK_KHZ)

`endif

/* File: logic/meter_period_timer.v */
// Metering period timer: one-cycle pulse at each period boundary
`timescale 1ns/10ps
module meter_period_timer #(
  parameter CNT_W      = 24,
  parameter FAST_CYCLES = 1675000,
  parameter SLOW_CYCLES = 12500000
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Speed select: 1 means 10 Mbps
  input  wire             slow_speed,
  // Boundary pulse
  output reg              period_tick
);

  reg  [CNT_W-1:0] count_ff;
  wire [CNT_W-1:0] limit;

  // Terminal count chosen by port speed
  assign limit = slow_speed ? SLOW_CYCLES[CNT_W-1:0] - 1'b1
                            : FAST_CYCLES[CNT_W-1:0] - 1'b1;

  // Free running period counter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff    <= {CNT_W{1'b0}};
      period_tick <= 1'b0;
    end else if (count_ff >= limit) begin
      count_ff    <= {CNT_W{1'b0}};
      period_tick <= 1'b1;
    end else begin
      count_ff    <= count_ff + 1'b1;
      period_tick <= 1'b0;
    end
  end

endmodule

/* File: logic/storm_port_meter.v */
// Per-port broadcast block counter with discard decision
`timescale 1ns/10ps
module storm_port_meter (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Period boundary and limit
  input  wire        period_tick,
  input  wire [10:0] limit,
  // One 64-byte broadcast block seen on this port
  input  wire        block_seen,
  // Discard further broadcast data
  output wire        discard
);

  reg [10:0] blocks_ff;
  reg [10:0] nxt_blocks;

  // Discard once count reaches limit
  assign discard = (blocks_ff >= limit);

  // Next count: restart at boundary, saturate at limit
  always @* begin
    nxt_blocks = blocks_ff;
    if (period_tick) begin
      nxt_blocks = 11'h000;
    end else if (block_seen && !discard) begin
      nxt_blocks = blocks_ff + 11'h001;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blocks_ff <= 11'h000;
    end else begin
      blocks_ff <= nxt_blocks;
    end
  end

endmodule

/* File: logic/switch_global_control_bank.v */
// Global control bank: storm threshold, factory bytes, LED and tag mode
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`include "storm_bank_defines.vh"
module switch_global_control_bank #(
  parameter NUM_PORTS   = 3,
  parameter FAST_CYCLES = `PERIOD_100M_CYC,
  parameter SLOW_CYCLES = `PERIOD_10M_CYC
) (
  // Clock and reset
  input  wire                 clk,
  input  wire                 rst_n,
  // Register port
  input  wire [7:0]           reg_addr,
  input  wire [7:0]           reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [7:0]           reg_rdata,
  // Strap pins
  input  wire                 strap_led_hi,
  input  wire                 strap_led_lo,
  // Per-port metering
  input  wire [NUM_PORTS-1:0] port_slow,
  input  wire [NUM_PORTS-1:0] bcast_block,
  output wire [NUM_PORTS-1:0] bcast_discard,
  // Mode outputs
  output wire [1:0]           led_mode,
  output wire                 test_mode,
  output wire                 direct_forward_tag_mode,
  output wire [10:0]          storm_limit
);

  // ==========================================================
  // Strap sampling
  // ==========================================================
  reg [1:0] strap_sync1_ff;
  reg [1:0] strap_sync2_ff;
  reg       strap_loaded_ff;

  // Two-stage synchroniser, unreset so it samples during reset
  always @(posedge clk) begin
    strap_sync1_ff <= {strap_led_hi, strap_led_lo};
    strap_sync2_ff <= strap_sync1_ff;
  end

  // Marks the first load after release
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_loaded_ff <= 1'b0;
    end else begin
      strap_loaded_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  reg [7:0] limit_high_ctrl_ff;
  reg [7:0] broadcast_limit_low_ff;
  reg [7:0] factory_test_a_ff;
  reg [7:0] factory_test_b_ff;
  reg [7:0] factory_test_c_ff;
  reg       strap_done_ff;
  wire      strap_load;
  wire      wr_hi;
  wire      wr_low;
  wire      wr_fa;
  wire      wr_fb;
  wire      wr_fc;
  wire      wr_led;

  // ==========================================================
  // Write decode
  // ==========================================================

  // One-cycle strap load, second edge after release
  assign strap_load = strap_loaded_ff && !strap_done_ff;

  // Write strobes; a LED/tag write in the strap cycle loses
  assign wr_hi  = reg_wr && (reg_addr == `OFS_LIMIT_HIGH_CTRL);
  assign wr_low = reg_wr && (reg_addr == `OFS_LIMIT_LOW);
  assign wr_fa  = reg_wr && (reg_addr == `OFS_FACTORY_A);
  assign wr_fb  = reg_wr && (reg_addr == `OFS_FACTORY_B);
  assign wr_fc  = reg_wr && (reg_addr == `OFS_FACTORY_C);
  assign wr_led = reg_wr && (reg_addr == `OFS_LED_TAG) && !strap_load;

  // ==========================================================
  // Strap load control
  // ==========================================================

  // Strap load done flag
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_ff <= 1'b0;
    end else if (strap_load) begin
      strap_done_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Threshold and factory bytes
  // ==========================================================

  // Threshold high control, only bits 2..0 used
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_high_ctrl_ff <= `RST_LIMIT_HIGH_CTRL;
    end else if (wr_hi) begin
      limit_high_ctrl_ff <= reg_wdata;
    end
  end

  // Threshold low byte
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      broadcast_limit_low_ff <= `RST_LIMIT_LOW;
    end else if (wr_low) begin
      broadcast_limit_low_ff <= reg_wdata;
    end
  end

  // Factory test byte A
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      factory_test_a_ff <= `RST_FACTORY_A;
    end else if (wr_fa) begin
      factory_test_a_ff <= reg_wdata;
    end
  end

  // Factory test byte B
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      factory_test_b_ff <= `RST_FACTORY_B;
    end else if (wr_fb) begin
      factory_test_b_ff <= reg_wdata;
    end
  end

  // Factory test byte C
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      factory_test_c_ff <= `RST_FACTORY_C;
    end else if (wr_fc) begin
      factory_test_c_ff <= reg_wdata;
    end
  end

  // ==========================================================
  // LED and tag register fields
  // ==========================================================
  localparam [7:0] LED_TAG_RST = `RST_LED_TAG_FIXED;

  reg        led_sel_hi_ff;
  reg  [1:0] led_rsvd_hi_ff;
  reg        test_mode_ff;
  reg  [1:0] led_rsvd_lo_ff;
  reg        led_sel_lo_ff;
  reg        tag_mode_ff;
  wire [7:0] led_and_tag_control;

  // Register image for reads
  assign led_and_tag_control = {led_sel_hi_ff, led_rsvd_hi_ff, test_mode_ff,
                                led_rsvd_lo_ff, led_sel_lo_ff, tag_mode_ff};

  // High LED select: strap at load, then software
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_sel_hi_ff <= LED_TAG_RST[`BIT_LED_SEL_HI];
    end else if (strap_load) begin
      led_sel_hi_ff <= strap_sync2_ff[1];
    end else if (wr_led) begin
      led_sel_hi_ff <= reg_wdata[`BIT_LED_SEL_HI];
    end
  end

  // Upper spare pair, reset 00, software writable
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_rsvd_hi_ff <= LED_TAG_RST[`BIT_RSVD_HI +: 2];
    end else if (wr_led) begin
      led_rsvd_hi_ff <= reg_wdata[`BIT_RSVD_HI +: 2];
    end
  end

  // Test mode enable, reset 0
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_mode_ff <= LED_TAG_RST[`BIT_TEST_MODE];
    end else if (wr_led) begin
      test_mode_ff <= reg_wdata[`BIT_TEST_MODE];
    end
  end

  // Lower spare pair, default 10
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_rsvd_lo_ff <= LED_TAG_RST[`BIT_RSVD_LO +: 2];
    end else if (wr_led) begin
      led_rsvd_lo_ff <= reg_wdata[`BIT_RSVD_LO +: 2];
    end
  end

  // Low LED select: strap at load, then software
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_sel_lo_ff <= LED_TAG_RST[`BIT_LED_SEL_LO];
    end else if (strap_load) begin
      led_sel_lo_ff <= strap_sync2_ff[0];
    end else if (wr_led) begin
      led_sel_lo_ff <= reg_wdata[`BIT_LED_SEL_LO];
    end
  end

  // Direct forward tag handling, reset 0
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tag_mode_ff <= LED_TAG_RST[`BIT_TAG_MODE];
    end else if (wr_led) begin
      tag_mode_ff <= reg_wdata[`BIT_TAG_MODE];
    end
  end

  // ==========================================================
  // Read port
  // ==========================================================
  reg [7:0] nxt_rdata;

  // Read mux, unmapped reads zero
  always @* begin
    case (reg_addr)
      `OFS_LIMIT_HIGH_CTRL: nxt_rdata = limit_high_ctrl_ff;
      `OFS_LIMIT_LOW:       nxt_rdata = broadcast_limit_low_ff;
      `OFS_FACTORY_A:       nxt_rdata = factory_test_a_ff;
      `OFS_FACTORY_B:       nxt_rdata = factory_test_b_ff;
      `OFS_FACTORY_C:       nxt_rdata = factory_test_c_ff;
      `OFS_LED_TAG:         nxt_rdata = led_and_tag_control;
      default:              nxt_rdata = 8'h00;
    endcase
  end

  // Read data valid the cycle after the strobe only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Mode outputs
  // ==========================================================
  assign led_mode = {led_sel_hi_ff, led_sel_lo_ff};
  assign test_mode = test_mode_ff;
  assign direct_forward_tag_mode = tag_mode_ff;

  // Eleven-bit threshold
  assign storm_limit = {limit_high_ctrl_ff[2:0],
                        broadcast_limit_low_ff};

  // ==========================================================
  // Broadcast storm metering
  // ==========================================================
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
      wire tick;
      // Period timer per port speed
      meter_period_timer #(
        .CNT_W       (24),
        .FAST_CYCLES (FAST_CYCLES),
        .SLOW_CYCLES (SLOW_CYCLES)
      ) u_timer (
        .clk         (clk),
        .rst_n       (rst_n),
        .slow_speed  (port_slow[p]),
        .period_tick (tick)
      );
      // Block counter and discard
      storm_port_meter u_meter (
        .clk         (clk),
        .rst_n       (rst_n),
        .period_tick (tick),
        .limit       (storm_limit),
        .block_seen  (bcast_block[p]),
        .discard     (bcast_discard[p])
      );
    end
  endgenerate

endmodule

/* File: sim/bank_sva.sv */
// Port assertions for the global control bank
`timescale 1ns/10ps
module bank_sva #(
  parameter NUM_PORTS = 3
) (
  // Clock, reset and register port
  input logic                 clk,
  input logic                 rst_n,
  input logic [7:0]           reg_addr,
  input logic [7:0]           reg_wdata,
  input logic                 reg_wr,
  input logic                 reg_rd,
  input logic [7:0]           reg_rdata,
  // Straps and metering
  input logic                 strap_led_hi,
  input logic                 strap_led_lo,
  input logic [NUM_PORTS-1:0] port_slow,
  input logic [NUM_PORTS-1:0] bcast_block,
  input logic [NUM_PORTS-1:0] bcast_discard,
  // Mode outputs
  input logic [1:0]           led_mode,
  input logic                 test_mode,
  input logic                 direct_forward_tag_mode,
  input logic [10:0]          storm_limit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Bus steps
  sequence s_wr(logic [7:0] a); reg_wr && reg_addr == a; endsequence
  sequence s_rd(logic [7:0] a); reg_rd && reg_addr == a; endsequence
  // ==========================================
  // Assertions
  AST_LIMIT_LO: assert property (s_wr(8'h07) |=>
    storm_limit[7:0] == $past(reg_wdata)) else $error("limit low");
  AST_LIMIT_HI: assert property (s_wr(8'h06) |=>
    storm_limit[10:8] == $past(reg_wdata[2:0])) else $error("limit high");
  AST_FACTORY: assert property (s_wr(8'h09) ##1 s_rd(8'h09) |=>
    reg_rdata == $past(reg_wdata, 2)) else $error("factory byte");
  AST_LED_MODE: assert property (s_rd(8'h0B) |=>
    led_mode == {reg_rdata[7], reg_rdata[1]}) else $error("led mode");
  AST_TEST_MODE: assert property (s_rd(8'h0B) |=>
    test_mode == reg_rdata[4]) else $error("test mode");
  AST_TAG_MODE: assert property (s_rd(8'h0B) |=>
    direct_forward_tag_mode == reg_rdata[0]) else $error("tag mode");
  AST_STRAP_HI: assert property ($rose(rst_n) |-> ##4
    led_mode[1] == strap_led_hi) else $error("strap high");
  AST_STRAP_LO: assert property ($rose(rst_n) |-> ##4
    led_mode[0] == strap_led_lo) else $error("strap low");
  AST_DISC_CAUSE: assert property ($rose(bcast_discard[0]) |->
    $past(bcast_block[0]) || $past(reg_wr)) else $error("discard cause");
  AST_FAST_PERIOD: assert property (
    bcast_discard[0] && !port_slow[0] |-> ##[0:52] !bcast_discard[0])
    else $error("fast period");
  AST_SLOW_PERIOD: assert property (
    bcast_discard[1] && port_slow[1] |-> ##[0:202] !bcast_discard[1])
    else $error("slow period");
endmodule

bind switch_global_control_bank bank_sva #(.NUM_PORTS(NUM_PORTS)) u_sva (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .strap_led_hi(strap_led_hi), .strap_led_lo(strap_led_lo),
  .port_slow(port_slow), .bcast_block(bcast_block),
  .bcast_discard(bcast_discard), .led_mode(led_mode), .test_mode(test_mode),
  .direct_forward_tag_mode(direct_forward_tag_mode),
  .storm_limit(storm_limit));

/* File: sim/testbench.sv */
// Self-checking bench for the global control bank
`timescale 1ns/10ps
module testbench;
  // Design signals and bench state
  logic        clk, rst_n, reg_wr, reg_rd, strap_led_hi, strap_led_lo;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
  logic [2:0]  port_slow, bcast_block, bcast_discard;
  logic [1:0]  led_mode;
  logic        test_mode, tag_mode;
  logic [10:0] storm_limit;
  logic [31:0] rows [7];
  int          error_cnt, n_checks, i, w, cyc;

  switch_global_control_bank #(.FAST_CYCLES(50), .SLOW_CYCLES(200)) DUT (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .strap_led_hi(strap_led_hi), .strap_led_lo(strap_led_lo),
    .port_slow(port_slow), .bcast_block(bcast_block),
    .bcast_discard(bcast_discard), .led_mode(led_mode),
    .test_mode(test_mode), .direct_forward_tag_mode(tag_mode),
    .storm_limit(storm_limit));

  // Clock and cycles since reset release
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;

  task chk(input string name, input logic [10:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, d);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, 2'b10};
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a);
    {reg_addr, reg_wr, reg_rd} <= {a, 2'b01};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task do_reset(input logic hi, lo);
    @(posedge clk);
    {rst_n, reg_wr, reg_rd, strap_led_hi, strap_led_lo} <= {3'b000, hi, lo};
    repeat (16) @(posedge clk);
    chk("reset limit", 11'h063, storm_limit);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog
  initial begin
    #400000 error_cnt++;
    end_sim;
  end

  // Main sequence: address, reset value, write value, readback
  initial begin
    {clk, rst_n, reg_addr, reg_wdata, reg_wr, reg_rd, bcast_block} = '0;
    {strap_led_hi, strap_led_lo, port_slow} = 5'b10010;
    rows = '{32'h06000505, 32'h07630202, 32'h08000000, 32'h09242424,
             32'h0A353535, 32'h0B880B0B, 32'h0C00FF00};
    do_reset(1'b1, 1'b0);
    for (i = 0; i < 7; i++) begin
      rd(rows[i][31:24]);
      chk("reset value", 11'(rows[i][23:16]), 11'(v));
    end
    for (i = 0; i < 7; i++) begin
      wr(rows[i][31:24], rows[i][15:8]);
      rd(rows[i][31:24]);
      chk("readback", 11'(rows[i][7:0]), 11'(v));
    end
    chk("storm limit", 11'h502, storm_limit);
    chk("led mode", 11'h001, 11'(led_mode));
    chk("test mode", 11'h000, 11'(test_mode));
    chk("tag mode", 11'h001, 11'(tag_mode));
    // Limit of two blocks, early in a slow period
    wr(8'h06, 8'h00);
    reg_wr <= 1'b0;
    while (cyc % 200 != 10) @(posedge clk);
    bcast_block <= 3'b111;
    repeat (3) @(posedge clk);
    bcast_block <= 3'b000;
    #1 chk("discard", 11'h007, 11'(bcast_discard));
    for (w = 0; w < 300 && bcast_discard[0]; w++) begin
      @(posedge clk);
      #1;
    end
    chk("fast clear", 11'h001, 11'(w >= 34 && w <= 40));
    chk("slow hold", 11'h001, 11'(bcast_discard[1]));
    for (; w < 300 && bcast_discard[1]; w++) begin
      @(posedge clk);
      #1;
    end
    chk("slow clear", 11'h001, 11'(w >= 184 && w <= 190));
    // Second reset with swapped straps
    do_reset(1'b0, 1'b1);
    rd(8'h0B);
    chk("strap reset", 11'h00A, 11'(v));
    wr(8'h0B, 8'h08);
    reg_wr <= 1'b0;
    #1 chk("led overwrite", 11'h000, 11'(led_mode));
    end_sim;
  end
endmodule
